//--- rtl/up_timer_map.vh
// Purpose: Register offsets, fields and reset values of the 16-bit up timer
// Assumes: Byte-wide register port, 4-bit address
// Notes: Included by the timer files only
`ifndef UP_TIMER_MAP_VH
`define UP_TIMER_MAP_VH
`define OFS_CNT_HI 4'h0
`define OFS_CNT_LO 4'h1
`define OFS_RLD_HI 4'h2
`define OFS_RLD_LO 4'h3
`define OFS_CTRL 4'h4
`define OFS_IRQ_STAT 4'h5
`define OFS_IRQ_MASK 4'h6
`define CTRL_EN_BIT 7
`define CTRL_ONESHOT_BIT 3
`define CTRL_PRE_MSB 2
`define CTRL_PRE_LSB 0
`define RST_CNT 16'h0001
`define RST_RLD 16'hFFFF
`define RST_BYTE 8'h00
`define CNT_ONE 16'h0001
`define CNT_ALL_ONES 16'hFFFF
`define CNT_ZERO 16'h0000
`define IRQ_RELOAD_BIT 0
`define IRQ_WRAP_BIT 1
`define PRE_WIDTH 3
`define PRE_DIV_WIDTH 7
`endif

//--- rtl/tick_prescaler.v
// Purpose: Divide the system clock by 2^sel to make a one-cycle count tick
// Assumes: sel 0..7 gives divide 1..128
// Notes: Counter held clear while not running
`timescale 1ns/1ns
`include "up_timer_map.vh"
module tick_prescaler
(
   input wire clk,
   input wire rstn,
   input wire run,
   input wire [`PRE_WIDTH-1:0] sel,
   output reg tick
);

reg [`PRE_DIV_WIDTH-1:0] div_r;
wire [`PRE_DIV_WIDTH-1:0] limit;

assign limit = (7'h01 << sel) - 7'h01;

always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      div_r <= 7'h00;
      tick <= 1'b0;
   end
   else if (!run)
   begin
      div_r <= 7'h00;
      tick <= 1'b0;
   end
   else if (div_r >= limit)
   begin
      div_r <= 7'h00;
      tick <= 1'b1;
   end
   else
   begin
      div_r <= div_r + 7'h01;
      tick <= 1'b0;
   end
end

endmodule

//--- rtl/up_timer.v
// Purpose: 16-bit up-counting timer with reload, prescaler and interrupt
// Assumes: Byte register port, read data one cycle after read strobe
// Notes: Continuous mode wraps; single-shot stops with count 0001 on the tick that reaches reload
`timescale 1ns/1ns
`include "up_timer_map.vh"
module up_timer
(
   input wire clk,
   input wire rstn,
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   output reg irq
);

////////////////////////////////////////////////////////////////
// State
reg [15:0] count_r;
reg [15:0] reload_r;
reg [7:0] ctrl_r;
reg [7:0] hold_lo_r;
reg [1:0] stat_r;
reg [1:0] mask_r;
reg [15:0] count_nxt;
reg [1:0] stat_nxt;
reg end_hit;
reg wrap_hit;
wire tick;
wire enabled;

assign enabled = ctrl_r[`CTRL_EN_BIT];

function hit;
   input [3:0] a;
   input [3:0] ofs;
   begin
      hit = (a == ofs);
   end
endfunction

tick_prescaler u_pre
(
   .clk(clk),
   .rstn(rstn),
   .run(enabled),
   .sel(ctrl_r[`CTRL_PRE_MSB:`CTRL_PRE_LSB]),
   .tick(tick)
);

////////////////////////////////////////////////////////////////
// Counter next value
always @*
begin
   count_nxt = count_r;
   end_hit = 1'b0;
   wrap_hit = 1'b0;
   if (enabled && tick)
   begin
      // Reload zero matches after the wrap, giving 65536 ticks
      if (ctrl_r[`CTRL_ONESHOT_BIT] && (count_r + `CNT_ONE == reload_r))
      begin
         end_hit = 1'b1;
         count_nxt = `CNT_ONE;
      end
      else
      begin
         count_nxt = count_r + `CNT_ONE;
         if (count_r == `CNT_ALL_ONES)
         begin
            wrap_hit = 1'b1;
            count_nxt = `CNT_ZERO;
         end
      end
   end
   if (wr && hit(addr, `OFS_CNT_HI))
   begin
      count_nxt[15:8] = wdata;
   end
   if (wr && hit(addr, `OFS_CNT_LO))
   begin
      count_nxt[7:0] = wdata;
   end
end

////////////////////////////////////////////////////////////////
// Interrupt status: set wins over read clear
always @*
begin
   stat_nxt = stat_r;
   if (rd && hit(addr, `OFS_IRQ_STAT))
   begin
      stat_nxt = 2'h0;
   end
   if (end_hit)
   begin
      stat_nxt[`IRQ_RELOAD_BIT] = 1'b1;
   end
   if (wrap_hit)
   begin
      stat_nxt[`IRQ_WRAP_BIT] = 1'b1;
   end
end

////////////////////////////////////////////////////////////////
// Registers
always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      count_r <= `RST_CNT;
      reload_r <= `RST_RLD;
      ctrl_r <= `RST_BYTE;
      hold_lo_r <= `RST_BYTE;
      stat_r <= 2'h0;
      mask_r <= 2'h0;
      irq <= 1'b0;
   end
   else
   begin
      count_r <= count_nxt;
      stat_r <= stat_nxt;
      irq <= |(stat_nxt & mask_r);
      if (rd && hit(addr, `OFS_CNT_HI) && enabled)
      begin
         hold_lo_r <= count_r[7:0];
      end
      if (wr && hit(addr, `OFS_RLD_HI))
      begin
         reload_r[15:8] <= wdata;
      end
      if (wr && hit(addr, `OFS_RLD_LO))
      begin
         reload_r[7:0] <= wdata;
      end
      if (wr && hit(addr, `OFS_IRQ_MASK))
      begin
         mask_r <= wdata[1:0];
      end
      if (wr && hit(addr, `OFS_CTRL))
      begin
         ctrl_r <= wdata;
      end
      else if (end_hit)
      begin
         ctrl_r[`CTRL_EN_BIT] <= 1'b0;
      end
   end
end

////////////////////////////////////////////////////////////////
// Read data, one cycle after the strobe
always @(posedge clk or negedge rstn)
begin
   if (!rstn)
   begin
      rdata <= `RST_BYTE;
   end
   else if (rd)
   begin
      case (addr)
         `OFS_CNT_HI: rdata <= count_r[15:8];
         `OFS_CNT_LO: rdata <= enabled ? hold_lo_r : count_r[7:0];
         `OFS_RLD_HI: rdata <= reload_r[15:8];
         `OFS_RLD_LO: rdata <= reload_r[7:0];
         `OFS_CTRL: rdata <= ctrl_r;
         `OFS_IRQ_STAT: rdata <= {6'h00, stat_r};
         `OFS_IRQ_MASK: rdata <= {6'h00, mask_r};
         default: rdata <= `RST_BYTE;
      endcase
   end
   else
   begin
      rdata <= `RST_BYTE;
   end
end

endmodule

//--- dv/up_timer_checker.sv
// Purpose: Port checks of the up timer
// Assumes: Register map of the timer
// Notes: Bound to up_timer
`timescale 1ns/1ns
module up_timer_checker
(
   input wire clk,
   input wire rstn,
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   input wire [7:0] rdata,
   input wire irq
);
reg [1:0] msk_r;
always @(posedge clk or negedge rstn)
   if (!rstn) msk_r <= 2'h0;
   else if (wr && addr == 4'h6) msk_r <= wdata[1:0];
default clocking cb @(posedge clk); endclocking
default disable iff (!rstn);
AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
   else $error("rdata not idle");
AST_UNMAP: assert property (rd && addr > 4'h6 |=> rdata == 8'h00)
   else $error("unmapped read");
AST_IRQ_MASK: assert property (irq |-> $past(msk_r) != 2'h0)
   else $error("irq unmasked");
AST_RLD_HI: assert property (wr && addr == 4'h2 ##1 rd && addr == 4'h2 |=> rdata == $past(wdata, 2))
   else $error("reload high");
AST_RLD_LO: assert property (wr && addr == 4'h3 ##1 rd && addr == 4'h3 |=> rdata == $past(wdata, 2))
   else $error("reload low");
AST_PRE: assert property (wr && addr == 4'h4 ##1 rd && addr == 4'h4 |=> rdata[2:0] == $past(wdata[2:0], 2))
   else $error("prescale");
AST_CNT_HI: assert property (wr && addr == 4'h4 && !wdata[7] ##1 wr && addr == 4'h0 ##1 rd && addr == 4'h0
   |=> rdata == $past(wdata, 2))
   else $error("count write");
AST_MASK: assert property (wr && addr == 4'h6 ##1 rd && addr == 4'h6 |=> rdata == $past(wdata, 2))
   else $error("mask");
endmodule
bind up_timer up_timer_checker chk_u(.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .irq(irq));

//--- dv/up_timer_tb.sv
// Purpose: Timer bench
// Assumes: Register map of the timer
// Notes: Random reloads over all prescales
`timescale 1ns/1ns
module up_timer_tb;
reg clk = 1'h0, rstn = 1'h0, wr = 1'h0, rd = 1'h0;
reg [3:0] addr = 4'h0;
reg [7:0] wdata = 8'h00;
wire [7:0] rdata;
wire irq;
integer miscompares = 0, total_checks = 0, cyc = 0, seed = 32'hC3A65BA9, i, n, t;
always #5 clk = ~clk;
always @(posedge clk)
begin
   cyc = cyc + 1;
   if (cyc > 90000)
   begin
      miscompares = miscompares + 1;
      tally_and_finish;
   end
end
up_timer dut_u(.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
function integer span(input [15:0] q, input [2:0] p);
   span = ((q == 16'h0000) ? 65536 : q) << p;
endfunction
// Write strobe stays up for back-to-back writes; r or idle lowers it
task w(input [3:0] a, input [7:0] d);
begin
   addr <= a;
   wdata <= d;
   wr <= 1'h1;
   @(posedge clk);
end
endtask
task idle;
begin
   wr <= 1'h0;
   @(posedge clk);
end
endtask
task ck(input [63:0] nm, input [7:0] g, input [7:0] e);
begin
   total_checks = total_checks + 1;
   if (g !== e)
   begin
      miscompares = miscompares + 1;
      $display("wrong value %0s at %h exp %h got %h", nm, addr, e, g);
   end
end
endtask
task ckirq(input e);
begin
   @(negedge clk);
   ck("irq", {7'h00, irq}, {7'h00, e});
   @(posedge clk);
end
endtask
task r(input [3:0] a, input [7:0] e);
begin
   wr <= 1'h0;
   addr <= a;
   rd <= 1'h1;
   @(posedge clk);
   rd <= 1'h0;
   @(negedge clk);
   ck("rdata", rdata, e);
   @(posedge clk);
end
endtask
task os(input [15:0] q, input [2:0] p);
begin
   w(4'h0, 8'h00);
   w(4'h1, 8'h00);
   w(4'h2, q[15:8]);
   w(4'h3, q[7:0]);
   w(4'h4, 8'h88 | p);
   idle;
   t = 0;
   while (irq !== 1'h1)
   begin
      @(negedge clk);
      t = t + 1;
   end
   @(posedge clk);
   // Prescaler restarts at the enable edge; interrupt is registered
   ck("timeout", {7'h00, t == span(q, p) + 1}, 8'h01);
   r(4'h5, 8'h01);
   r(4'h0, 8'h00);
   r(4'h1, 8'h01);
   r(4'h4, 8'h08 | p);
   ckirq(1'h0);
end
endtask
task tally_and_finish;
begin
   $display("checks %0d mismatches %0d", total_checks, miscompares);
   if (miscompares == 0 && total_checks > 0)
      $display("No errors found");
   else
      $display("Errors were found");
   $finish;
end
endtask
initial
begin
   repeat (20) @(posedge clk);
   rstn <= 1'h1;
   @(posedge clk);
   r(4'h0, 8'h00);
   r(4'h1, 8'h01);
   r(4'h2, 8'hFF);
   r(4'h3, 8'hFF);
   r(4'h4, 8'h00);
   w(4'hF, 8'hAA);
   r(4'hF, 8'h00);
   w(4'h2, 8'h12);
   r(4'h2, 8'h12);
   w(4'h3, 8'h34);
   r(4'h3, 8'h34);
   w(4'h4, 8'h05);
   r(4'h4, 8'h05);
   w(4'h4, 8'h00);
   w(4'h0, 8'h5A);
   r(4'h0, 8'h5A);
   w(4'h0, 8'h12);
   w(4'h1, 8'h30);
   w(4'h4, 8'h87);
   r(4'h0, 8'h12);
   repeat (300) @(posedge clk);
   r(4'h1, 8'h30);
   w(4'h0, 8'h40);
   r(4'h0, 8'h40);
   w(4'h4, 8'h07);
   // Two divide-by-128 ticks have landed; disabled reads are live
   r(4'h1, 8'h32);
   // Reset in mid-run brings back the reset values
   rstn <= 1'h0;
   repeat (2) @(posedge clk);
   rstn <= 1'h1;
   @(posedge clk);
   r(4'h0, 8'h00);
   r(4'h1, 8'h01);
   r(4'h2, 8'hFF);
   r(4'h4, 8'h00);
   w(4'h6, 8'h00);
   w(4'h0, 8'hFF);
   w(4'h1, 8'hFE);
   w(4'h4, 8'h80);
   idle;
   repeat (20) @(posedge clk);
   ckirq(1'h0);
   w(4'h4, 8'h00);
   r(4'h0, 8'h00);
   w(4'h6, 8'h03);
   r(4'h6, 8'h03);
   ckirq(1'h1);
   r(4'h5, 8'h02);
   ckirq(1'h0);
   for (i = 0; i < 8; i = i + 1)
   begin
      n = $random(seed);
      os({13'h0000, n[2:0]} + 16'h0001, i[2:0]);
   end
   os(16'h0001, 3'h0);
   os(16'h0000, 3'h0);
   tally_and_finish;
end
endmodule
